// *** shared/prhg_consts.svh ***
// constants for the random generator health gate
// assumes inclusion by the logic files only
`ifndef PRHG_CONSTS_SVH
`define PRHG_CONSTS_SVH
`define PRHG_OCTET_W 8
`define PRHG_STUCK_LIMIT 32
`define PRHG_WIN_LEN 1024
`define PRHG_ONES_LO 412
`define PRHG_ONES_HI 612
`define PRHG_WIN_W 11
`define PRHG_RUN_W 6
`define PRHG_BIT_W 3
`endif

// *** shared/prhg_pkg.sv ***
// types for the random generator health gate
// assumes prhg_consts.svh is on the include path
package prhg_pkg;
	typedef enum logic [1:0] {
		PRHG_ST_STARTUP,
		PRHG_ST_RUN,
		PRHG_ST_FAIL
	} prhg_state_t;
endpackage : prhg_pkg

// *** logic/prhg_stuck_det.sv ***
// total-failure detector: flags an over-long run of equal raw bits
// assumes raw bits arrive qualified by i_raw_vld, synchronous to i_clk
`timescale 1ns/1ps
`include "prhg_consts.svh"
module prhg_stuck_det import prhg_pkg::*; #(
	parameter int RUN_LIMIT = `PRHG_STUCK_LIMIT
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// raw stream
	input wire logic i_raw_vld,
	input wire logic i_raw_bit,
	// result
	output logic o_stuck
);
	logic [`PRHG_RUN_W-1:0] run_ff;
	logic last_ff;
	logic stuck_ff;

	// limit must fit the run counter, refused at elaboration
	if (RUN_LIMIT < 2 || RUN_LIMIT >= (1 << `PRHG_RUN_W)) begin : g_limit_range
		$error("prhg_stuck_det: RUN_LIMIT out of range");
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			run_ff <= '0;
			last_ff <= 1'b0;
		end else if (i_raw_vld) begin
			last_ff <= i_raw_bit;
			if (run_ff == '0 || i_raw_bit != last_ff)
				run_ff <= `PRHG_RUN_W'(1);
			else if (run_ff != '1)
				run_ff <= run_ff + `PRHG_RUN_W'(1);
		end
	end

	// pulses one cycle after the bit that completes the run, registered
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			stuck_ff <= 1'b0;
		else
			stuck_ff <= i_raw_vld && run_ff != '0 && i_raw_bit == last_ff
				&& run_ff == `PRHG_RUN_W'(RUN_LIMIT - 1);
	end

	assign o_stuck = stuck_ff;
endmodule : prhg_stuck_det

// *** logic/prhg_gate.sv ***
// health gate of a physical random generator: stuck test, windowed
// ones-count online test, octet packing and output blocking
// assumes an external entropy source and software reading octets
// How it works
// - A run-length stuck test watches the raw bits from the first one after start.
// - After a total failure no octet is ever presented at the output.
// - The octet being packed when the source dies is discarded, never released.
// - A ones-count test over each window runs at start-up and then forever.
// - Octets are blocked until the first window passes and after any defect.
// - The online test is continuous, each window is judged on its last bit.
// - Random data leaves as eight-bit octets with a valid/ready handshake.
// - Entropy per bit is the source's duty; the window bounds reject gross bias.
// - Software sees one pass line and one fail line of the test sequence.
`timescale 1ns/1ps
`include "prhg_consts.svh"
module prhg_gate import prhg_pkg::*; #(
	parameter int WIN_LEN = `PRHG_WIN_LEN,
	parameter int ONES_LO = `PRHG_ONES_LO,
	parameter int ONES_HI = `PRHG_ONES_HI,
	parameter int STUCK_LIMIT = `PRHG_STUCK_LIMIT
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// raw entropy source
	input wire logic i_raw_vld,
	input wire logic i_raw_bit,
	// octet output to software
	output logic o_oct_vld,
	input wire logic i_oct_rdy,
	output logic [`PRHG_OCTET_W-1:0] o_oct_data,
	// health result
	output logic o_pass,
	output logic o_fail
);
	prhg_state_t state_ff;
	logic stuck;
	logic [`PRHG_WIN_W-1:0] win_cnt_ff;
	logic [`PRHG_WIN_W-1:0] ones_ff;
	logic [`PRHG_WIN_W-1:0] ones_now;
	logic win_end;
	logic win_bad;
	logic [`PRHG_OCTET_W-1:0] shift_ff;
	logic [`PRHG_BIT_W-1:0] bit_cnt_ff;
	logic [`PRHG_OCTET_W-1:0] oct_ff;
	logic oct_vld_ff;
	logic pass_ff;
	logic fail_ff;
	logic win_fail;
	logic oct_kill;
	logic oct_load;
	wire logic [`PRHG_OCTET_W-1:0] nxt_shift;

	// parameter checks, refused at elaboration
	if (WIN_LEN < `PRHG_OCTET_W) begin : g_win_short
		$error("prhg_gate: WIN_LEN shorter than one octet");
	end
	if (WIN_LEN >= (1 << `PRHG_WIN_W)) begin : g_win_long
		$error("prhg_gate: WIN_LEN overflows the window counter");
	end
	if (ONES_LO < 0 || ONES_LO > ONES_HI) begin : g_ones_order
		$error("prhg_gate: ones bounds out of order");
	end
	if (ONES_HI > WIN_LEN) begin : g_ones_high
		$error("prhg_gate: upper ones bound beyond the window");
	end
	if (STUCK_LIMIT < 2 || STUCK_LIMIT >= (1 << `PRHG_RUN_W)) begin : g_stuck_range
		$error("prhg_gate: STUCK_LIMIT out of range");
	end

	prhg_stuck_det #(
		.RUN_LIMIT(STUCK_LIMIT)
	) u_stuck (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_raw_vld(i_raw_vld),
		.i_raw_bit(i_raw_bit),
		.o_stuck(stuck)
	);

	// windowed ones count, continuous
	assign ones_now = ones_ff + `PRHG_WIN_W'(i_raw_bit);
	assign win_end = i_raw_vld && win_cnt_ff == `PRHG_WIN_W'(WIN_LEN - 1);
	assign win_bad = ones_now < `PRHG_WIN_W'(ONES_LO)
		|| ones_now > `PRHG_WIN_W'(ONES_HI);
	assign win_fail = win_end && win_bad;

	// bit position inside the current window
	always_ff @(posedge i_clk) begin
		if (!i_nrst || win_end)
			win_cnt_ff <= '0;
		else if (i_raw_vld)
			win_cnt_ff <= win_cnt_ff + `PRHG_WIN_W'(1);
	end

	// ones seen so far in the current window
	always_ff @(posedge i_clk) begin
		if (!i_nrst || win_end)
			ones_ff <= '0;
		else if (i_raw_vld)
			ones_ff <= ones_now;
	end

	// health state
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			state_ff <= PRHG_ST_STARTUP;
		else
			case (state_ff)
				PRHG_ST_STARTUP: begin
					if (stuck || (win_end && win_bad))
						state_ff <= PRHG_ST_FAIL;
					else if (win_end)
						state_ff <= PRHG_ST_RUN;
				end
				PRHG_ST_RUN: begin
					if (stuck || (win_end && win_bad))
						state_ff <= PRHG_ST_FAIL;
				end
				PRHG_ST_FAIL: state_ff <= PRHG_ST_FAIL;
				default: state_ff <= PRHG_ST_FAIL;
			endcase
	end

	// octet packing, partial octet dropped on stuck
	// bit 0 takes the newest raw bit, each higher bit its lower neighbour
	for (genvar b = 0; b < `PRHG_OCTET_W; b++) begin : g_shift
		if (b == 0) begin : g_head
			assign nxt_shift[b] = i_raw_bit;
		end else begin : g_tail
			assign nxt_shift[b] = shift_ff[b-1];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst || stuck)
			shift_ff <= '0;
		else if (i_raw_vld)
			shift_ff <= nxt_shift;
	end

	// position inside the octet being packed
	always_ff @(posedge i_clk) begin
		if (!i_nrst || stuck)
			bit_cnt_ff <= '0;
		else if (i_raw_vld)
			bit_cnt_ff <= bit_cnt_ff + `PRHG_BIT_W'(1);
	end

	// an octet dies with a stuck pulse, a failed state or a failing window
	assign oct_kill = stuck || state_ff == PRHG_ST_FAIL || win_fail;
	// the last bit of an octet loads it once the first window has passed
	assign oct_load = i_raw_vld && bit_cnt_ff == '1
		&& (state_ff == PRHG_ST_RUN || win_end);

	// output holding register, data
	always_ff @(posedge i_clk) begin
		if (!i_nrst || oct_kill)
			oct_ff <= '0;
		else if (oct_load)
			oct_ff <= nxt_shift;
	end

	// output holding register, valid; a new octet wins over a take
	always_ff @(posedge i_clk) begin
		if (!i_nrst || oct_kill)
			oct_vld_ff <= 1'h0;
		else if (oct_load)
			oct_vld_ff <= 1'h1;
		else if (i_oct_rdy)
			oct_vld_ff <= 1'h0;
	end

	// pass follows the run state, dropped at once by a stuck pulse
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			pass_ff <= 1'h0;
		else
			pass_ff <= state_ff == PRHG_ST_RUN && !stuck;
	end

	// fail rises with the stuck pulse so pass and fail hand over on one edge
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			fail_ff <= 1'h0;
		else
			fail_ff <= fail_ff || stuck || state_ff == PRHG_ST_FAIL;
	end

	assign o_oct_vld = oct_vld_ff && state_ff == PRHG_ST_RUN && !stuck;
	assign o_oct_data = oct_ff;
	assign o_pass = pass_ff;
	assign o_fail = fail_ff;
endmodule : prhg_gate

// *** dv/prhg_gate_checker.sv ***
// port checker for prhg_gate
// assumes binding onto every prhg_gate instance
`timescale 1ns/1ps
module prhg_gate_checker #(
	parameter int WIN_LEN = 1024,
	parameter int STUCK_LIMIT = 32
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// inputs of the gate
	input wire logic i_raw_vld,
	input wire logic i_raw_bit,
	input wire logic i_oct_rdy,
	// outputs of the gate
	input wire logic o_oct_vld,
	input wire logic o_pass,
	input wire logic o_fail,
	input wire logic [7:0] o_oct_data
);
	logic [5:0] run_ff;
	logic last_ff;
	logic [11:0] nbits_ff;
	always_ff @(posedge i_clk) if (!i_nrst) last_ff <= 1'b0; else if (i_raw_vld) last_ff <= i_raw_bit;
	always_ff @(posedge i_clk) begin
		if (!i_nrst) run_ff <= 6'h0;
		else if (i_raw_vld) run_ff <= (i_raw_bit == last_ff && run_ff != 0) ? run_ff + 6'h1 : 6'h1;
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) nbits_ff <= 12'h0;
		else if (i_raw_vld && nbits_ff != 12'hFFF) nbits_ff <= nbits_ff + 12'h1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	a_fail_blocks: assert property (o_fail |-> !o_oct_vld && !o_pass) else $error("out when failed");
	a_fail_sticky: assert property (o_fail |=> o_fail) else $error("fail dropped");
	a_pass_hold: assert property (o_pass |=> o_pass || o_fail) else $error("pass lost");
	a_win_first: assert property (o_pass || o_oct_vld |-> nbits_ff >= WIN_LEN) else $error("early");
	a_stuck_fail: assert property (run_ff == STUCK_LIMIT |-> ##[1:2] o_fail) else $error("no fail");
	a_stuck_quiet: assert property (run_ff == STUCK_LIMIT |-> !o_oct_vld [*3]) else $error("leak");
	a_vld_hold: assert property (o_oct_vld && !i_oct_rdy && !i_raw_vld |=>
		o_oct_vld && $stable(o_oct_data)) else $error("octet lost");
	a_take_clr: assert property (o_oct_vld && i_oct_rdy && !i_raw_vld |=> !o_oct_vld) else $error("take");
	c_pass: cover property ($rose(o_pass));
	c_fail: cover property ($rose(o_fail));
	c_take: cover property (o_oct_vld && i_oct_rdy);
endmodule : prhg_gate_checker
bind prhg_gate prhg_gate_checker #(.WIN_LEN(WIN_LEN), .STUCK_LIMIT(STUCK_LIMIT)) chk_i (.i_clk,
	.i_nrst, .i_raw_vld, .i_raw_bit, .i_oct_rdy, .o_oct_vld, .o_pass, .o_fail, .o_oct_data);

// *** dv/prhg_src.sv ***
// entropy source model, one raw bit per cycle while enabled, msb of pattern first
// assumes the bench changes the pattern only at octet boundaries
`timescale 1ns/1ps
module prhg_src (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// bench control
	input wire logic i_en,
	input wire logic i_stuck,
	input wire logic [7:0] i_pat,
	// raw stream into the gate
	output logic o_vld,
	output logic o_bit
);
	logic [2:0] idx_ff;
	logic tgl_ff;
	always_ff @(posedge i_clk) if (!i_nrst) idx_ff <= 3'h0; else if (i_en) idx_ff <= idx_ff + 3'h1;
	always_ff @(posedge i_clk) tgl_ff <= i_nrst ? !tgl_ff : 1'b0;
	assign o_vld = i_en;
	// idle line toggles so a stale bit is never seen
	assign o_bit = !i_en ? tgl_ff : (i_stuck ? 1'b1 : i_pat[3'h7 - idx_ff]);
endmodule : prhg_src

// *** dv/tb.sv ***
// self-checking bench for prhg_gate with small window settings
// assumes a 40 MHz clock and the source model
`timescale 1ns/1ps
module tb;
	logic clk, nrst, en, stuck, rdy, vld, rbit, ovld, pass, fail;
	logic [7:0] pat, data;
	int error_cnt, check_count, sw_ones;
	logic [15:0] rows [4] = '{16'h1E1E, 16'hC3C3, 16'h5A5A, 16'h0F0F};
	prhg_gate #(.WIN_LEN(64), .ONES_LO(16), .ONES_HI(48), .STUCK_LIMIT(32)) prhg_gate_i (.i_clk(clk),
		.i_nrst(nrst), .i_raw_vld(vld), .i_raw_bit(rbit), .o_oct_vld(ovld), .i_oct_rdy(rdy),
		.o_oct_data(data), .o_pass(pass), .o_fail(fail));
	prhg_src prhg_src_i (.i_clk(clk), .i_nrst(nrst), .i_en(en), .i_stuck(stuck), .i_pat(pat),
		.o_vld(vld), .o_bit(rbit));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic step(int n);
		repeat (n) @(negedge clk);
	endtask : step
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		#20us;
		error_cnt++;
		summarize;
	end
	initial begin
		nrst = 0; en = 0; stuck = 0; rdy = 1; pat = 8'hA5; error_cnt = 0; check_count = 0;
		sw_ones = 0;
		step(4);
		chk("rst out", 8'h00, {fail, ovld, pass});
		nrst = 1;
		en = 1;
		step(63);
		chk("early", 8'h00, {ovld, pass});
		step(1);
		chk("first", 8'hA5, ovld ? data : 8'hEE);
		foreach (rows[k]) begin
			pat = rows[k][15:8];
			step(8);
			chk("vld", 8'h01, ovld);
			chk("octet", rows[k][7:0], data);
			sw_ones += $countones(data);
		end
		chk("pass", 8'h01, pass);
		chk("sw ones", 8'h01, 8'(sw_ones >= 8 && sw_ones <= 24));
		en = 0; rdy = 0;
		step(3);
		chk("held", 8'h0F, ovld ? data : 8'hEE);
		rdy = 1;
		step(1);
		chk("taken", 8'h00, ovld);
		en = 1; stuck = 1;
		step(40);
		chk("fail", 8'h01, fail);
		chk("vld", 8'h00, ovld);
		stuck = 0;
		step(16);
		chk("fail", 8'h04, {fail, ovld, pass});
		en = 0; nrst = 0;
		step(4);
		nrst = 1;
		chk("fail", 8'h00, fail);
		chk("rst data", 8'h00, data);
		pat = 8'hFE; en = 1;
		step(70);
		chk("fail", 8'h04, {fail, ovld, pass});
		summarize;
	end
endmodule : tb
